// [pkg/ts_slot_pkg.sv]
// constants, field layout and sample record for the event timestamp sample slots
// assumes a 125 MHz register clock and a time clock that gives a 40 ns tick
//
// Overview of operation
// - unit index bit selects which unit reads
// - bit 30 shows edge: 1 rising
// - second sample nanoseconds in bits 29:0
// - third sample nanoseconds in bits 29:0
// - second sample seconds, full 32 bits
// - third sample seconds, full 32 bits
// - 3-bit phase code names 8 ns slot
// - code 100 is 32 ns; rest reserved
// - capture only software-enabled edge polarities
// - overflow sets, event count holds at 15
package ts_slot_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned SLOT_NS = 8;
    localparam int unsigned TC_PERIOD_NS = 40;
    localparam int unsigned SLOT_CYCLES = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PHASE_SLOTS = TC_PERIOD_NS / SLOT_NS;
    localparam logic [3:0] SLOT_TMR_LAST = 4'(SLOT_CYCLES - 1);
    localparam logic [2:0] PHASE_LAST = 3'(PHASE_SLOTS - 1);

    // ==========================================================
    // register offsets
    localparam logic [11:0] INDEX_OFFS = 12'h500;
    localparam logic [11:0] CTRL_OFFS = 12'h550;
    localparam logic [11:0] NS2_OFFS = 12'h560;
    localparam logic [11:0] SEC2_OFFS = 12'h564;
    localparam logic [11:0] PH2_OFFS = 12'h568;
    localparam logic [11:0] NS3_OFFS = 12'h56C;
    localparam logic [11:0] SEC3_OFFS = 12'h570;
    localparam logic [11:0] PH3_OFFS = 12'h574;

    // ==========================================================
    // field positions and values
    localparam int unsigned UNIT_PTR_BIT = 8;
    localparam int unsigned EDGE_BIT = 30;
    localparam int unsigned RISE_EN_BIT = 7;
    localparam int unsigned FALL_EN_BIT = 6;
    localparam int unsigned OVF_BIT = 16;
    localparam int unsigned CNT_LSB = 24;
    localparam int unsigned CLR_BIT = 31;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_BEFORE_2ND = 4'h1;
    localparam logic [3:0] CNT_BEFORE_3RD = 4'h2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // ==========================================================
    // phase codes; 16 ns code is ambiguous, a parameter of the top
    localparam logic [2:0] PH_0NS = 3'h0;
    localparam logic [2:0] PH_8NS = 3'h1;
    localparam logic [2:0] PH_16NS_DEFAULT = 3'h2;
    localparam logic [2:0] PH_24NS = 3'h3;
    localparam logic [2:0] PH_32NS = 3'h4;

    typedef struct packed {
        logic rising;
        logic [29:0] nsec;
        logic [31:0] sec;
        logic [2:0] phase;
    } sample_t;

endpackage : ts_slot_pkg

// [pkg/slot_if.sv]
// load port and stored value of one sample slot
// assumes one owner that loads and one slot that stores
`timescale 1ns/10ps
`default_nettype none
interface slot_if;
    logic load;
    ts_slot_pkg::sample_t din;
    ts_slot_pkg::sample_t q;
    modport owner (output load, output din, input q);
    modport slot (input load, input din, output q);
endinterface : slot_if
`default_nettype wire

// [rtl/event_sync.sv]
// two-flop synchroniser for an event pin plus edge detection
// assumes the pin is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module event_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;

    sync_t r;
    sync_t nxt;

    always_comb begin
        nxt.s1 = pin;
        nxt.s2 = r.s1;
        nxt.s3 = r.s2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // only s2 and s3 feed edge logic; s1 may be metastable
    assign rise = r.s2 & ~r.s3;
    assign fall = ~r.s2 & r.s3;
endmodule : event_sync
`default_nettype wire

// [rtl/sample_slot.sv]
// one captured sample: edge, nanoseconds, seconds, phase
// assumes the owner pulses load for one cycle per capture
`timescale 1ns/10ps
`default_nettype none
module sample_slot (
    input wire logic clk,
    input wire logic rst,
    slot_if.slot bus
);
    typedef struct packed {
        ts_slot_pkg::sample_t s;
    } slot_state_t;

    slot_state_t r;
    slot_state_t nxt;

    always_comb begin
        nxt = r;
        if (bus.load) begin
            nxt.s = bus.din;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign bus.q = r.s;
endmodule : sample_slot
`default_nettype wire

// [rtl/ts_sample_regs.sv]
// two event timestamp units with second and third sample slots behind APB
// assumes tc_sec/tc_nsec/tc_tick come from the time clock on clk; evt_pin is asynchronous
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ts_sample_regs #(
    parameter logic [2:0] PH_16NS_CODE = ts_slot_pkg::PH_16NS_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] evt_pin,
    input wire logic [31:0] tc_sec,
    input wire logic [29:0] tc_nsec,
    input wire logic tc_tick
);
    // ==========================================================
    // state
    typedef struct packed {
        logic unit_ptr;
        logic [1:0] rise_en;
        logic [1:0] fall_en;
        logic [1:0][3:0] cnt;
        logic [1:0] ovf;
        logic [3:0] tmr;
        logic [2:0] phase_cnt;
        logic [31:0] rdata;
        logic err;
    } regs_t;

    regs_t r;
    regs_t nxt;

    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] hit;
    logic [1:0] clr;
    logic [3:0] slot_load;
    logic [2:0] cur_phase;
    logic setup;
    logic wr_acc;
    ts_slot_pkg::sample_t sq [4];

    slot_if sif [4] ();

    function automatic logic [2:0] phase_code(input logic [2:0] idx);
        case (idx)
            3'h0: phase_code = ts_slot_pkg::PH_0NS;
            3'h1: phase_code = ts_slot_pkg::PH_8NS;
            3'h2: phase_code = PH_16NS_CODE;
            3'h3: phase_code = ts_slot_pkg::PH_24NS;
            3'h4: phase_code = ts_slot_pkg::PH_32NS;
            default: phase_code = ts_slot_pkg::PH_0NS;
        endcase
    endfunction : phase_code

    assign setup = psel & ~penable;
    // zero wait states: every access phase completes
    assign wr_acc = psel & penable & pwrite;
    assign cur_phase = phase_code(r.phase_cnt);

    // ==========================================================
    // per-unit edge detection and slot loading
    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_unit
            event_sync u_sync (
                .clk(clk),
                .rst(rst),
                .pin(evt_pin[u]),
                .rise(rise[u]),
                .fall(fall[u])
            );
            assign hit[u] = (rise[u] & r.rise_en[u]) | (fall[u] & r.fall_en[u]);
            assign clr[u] = wr_acc & (paddr == ts_slot_pkg::CTRL_OFFS)
                & pwdata[ts_slot_pkg::CLR_BIT] & (r.unit_ptr == 1'(u));
            // a clear in the same cycle makes this edge the first one again
            assign slot_load[2 * u] = hit[u] & ~clr[u]
                & (r.cnt[u] == ts_slot_pkg::CNT_BEFORE_2ND);
            assign slot_load[2 * u + 1] = hit[u] & ~clr[u]
                & (r.cnt[u] == ts_slot_pkg::CNT_BEFORE_3RD);
        end
    endgenerate

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_slot
            assign sif[k].load = slot_load[k];
            assign sif[k].din.rising = rise[k / 2];
            assign sif[k].din.nsec = tc_nsec;
            assign sif[k].din.sec = tc_sec;
            assign sif[k].din.phase = cur_phase;
            assign sq[k] = sif[k].q;
            sample_slot u_slot (
                .clk(clk),
                .rst(rst),
                .bus(sif[k])
            );
        end
    endgenerate

    // ==========================================================
    // next state
    always_comb begin
        logic [3:0] c;
        logic o;
        logic [1:0] si;
        c = '0;
        o = 1'b0;
        si = {r.unit_ptr, 1'b0};
        nxt = r;

        // 8 ns slot within the 40 ns time clock period
        if (tc_tick) begin
            nxt.tmr = '0;
            nxt.phase_cnt = '0;
        end else if (r.tmr == ts_slot_pkg::SLOT_TMR_LAST) begin
            nxt.tmr = '0;
            if (r.phase_cnt != ts_slot_pkg::PHASE_LAST) begin
                nxt.phase_cnt = r.phase_cnt + 3'h1;
            end
        end else begin
            nxt.tmr = r.tmr + 4'h1;
        end

        for (int i = 0; i < 2; i++) begin
            c = clr[i] ? 4'h0 : r.cnt[i];
            o = clr[i] ? 1'b0 : r.ovf[i];
            if (hit[i]) begin
                if (c == ts_slot_pkg::CNT_MAX) begin
                    o = 1'b1;
                end else begin
                    c = c + 4'h1;
                end
            end
            nxt.cnt[i] = c;
            nxt.ovf[i] = o;
        end

        if (wr_acc && paddr == ts_slot_pkg::INDEX_OFFS) begin
            nxt.unit_ptr = pwdata[ts_slot_pkg::UNIT_PTR_BIT];
        end
        if (wr_acc && paddr == ts_slot_pkg::CTRL_OFFS) begin
            nxt.rise_en[r.unit_ptr] = pwdata[ts_slot_pkg::RISE_EN_BIT];
            nxt.fall_en[r.unit_ptr] = pwdata[ts_slot_pkg::FALL_EN_BIT];
        end

        // read data is latched in the setup cycle so prdata comes from a flop
        if (setup) begin
            nxt.rdata = ts_slot_pkg::RESET_WORD;
            nxt.err = 1'b0;
            case (paddr)
                ts_slot_pkg::INDEX_OFFS: begin
                    nxt.rdata[ts_slot_pkg::UNIT_PTR_BIT] = r.unit_ptr;
                end
                ts_slot_pkg::CTRL_OFFS: begin
                    nxt.rdata[ts_slot_pkg::RISE_EN_BIT] = r.rise_en[r.unit_ptr];
                    nxt.rdata[ts_slot_pkg::FALL_EN_BIT] = r.fall_en[r.unit_ptr];
                    nxt.rdata[ts_slot_pkg::OVF_BIT] = r.ovf[r.unit_ptr];
                    nxt.rdata[ts_slot_pkg::CNT_LSB +: 4] = r.cnt[r.unit_ptr];
                end
                ts_slot_pkg::NS2_OFFS: begin
                    nxt.rdata[ts_slot_pkg::EDGE_BIT] = sq[si].rising;
                    nxt.rdata[29:0] = sq[si].nsec;
                end
                ts_slot_pkg::SEC2_OFFS: begin
                    nxt.rdata = sq[si].sec;
                end
                ts_slot_pkg::PH2_OFFS: begin
                    nxt.rdata[2:0] = sq[si].phase;
                end
                ts_slot_pkg::NS3_OFFS: begin
                    nxt.rdata[ts_slot_pkg::EDGE_BIT] = sq[si + 2'h1].rising;
                    nxt.rdata[29:0] = sq[si + 2'h1].nsec;
                end
                ts_slot_pkg::SEC3_OFFS: begin
                    nxt.rdata = sq[si + 2'h1].sec;
                end
                ts_slot_pkg::PH3_OFFS: begin
                    nxt.rdata[2:0] = sq[si + 2'h1].phase;
                end
                default: begin
                    nxt.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign prdata = r.rdata;
    assign pslverr = r.err;
    assign pready = 1'b1;

    // ==========================================================
    // checks
    logic [31:0] sec_u1_2nd;
    logic [2:0] ph_u0_2nd;
    logic [3:0] cnt_u0;
    assign sec_u1_2nd = sq[2].sec;
    assign ph_u0_2nd = sq[0].phase;
    assign cnt_u0 = r.cnt[0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_unit_select: assert property (
        (setup && paddr == ts_slot_pkg::SEC2_OFFS && r.unit_ptr)
        |=> (prdata == $past(sec_u1_2nd)))
        else $error("seconds read ignores unit pointer");
    a_edge_rising: assert property (
        slot_load[0] |=> (sq[0].rising == $past(rise[0])))
        else $error("second sample edge polarity wrong");
    a_ns_second: assert property (
        slot_load[0] |=> (sq[0].nsec == $past(tc_nsec)))
        else $error("second sample nanoseconds wrong");
    a_ns_third: assert property (
        slot_load[1] |=> (sq[1].nsec == $past(tc_nsec)))
        else $error("third sample nanoseconds wrong");
    a_sec_second: assert property (
        slot_load[0] |=> (sq[0].sec == $past(tc_sec)))
        else $error("second sample seconds wrong");
    a_sec_third: assert property (
        slot_load[1] |=> (sq[1].sec == $past(tc_sec)))
        else $error("third sample seconds wrong");
    a_phase_slot: assert property (
        (tc_tick ##1 !tc_tick ##1 (!tc_tick && slot_load[0]))
        |=> (ph_u0_2nd == ts_slot_pkg::PH_8NS))
        else $error("phase code not the second 8 ns slot");
    a_phase_code: assert property (
        (r.phase_cnt == ts_slot_pkg::PHASE_LAST) |-> (cur_phase == ts_slot_pkg::PH_32NS))
        else $error("fifth slot not coded as 32 ns");
    a_edge_gate: assert property (
        (!r.rise_en[0] && !r.fall_en[0] && !clr[0]) |=> (cnt_u0 == $past(cnt_u0)))
        else $error("count moved with detection disabled");
    a_ovf_hold: assert property (
        (cnt_u0 == ts_slot_pkg::CNT_MAX && hit[0] && !clr[0])
        |=> (r.ovf[0] && cnt_u0 == ts_slot_pkg::CNT_MAX))
        else $error("overflow not set or count left 15");
    a_reserved_zero: assert property (
        (setup && paddr == ts_slot_pkg::PH2_OFFS) |=> (prdata[31:3] == 29'h0 && !pslverr))
        else $error("reserved phase bits not zero");

    // ==========================================================
    // unit one slots, indexed reads and phase timing
    // unit one gets the nanoseconds, seconds and second-sample edge checks of unit zero, but no phase or third-sample edge check

    a_unit_third_ns: assert property (
        (setup && paddr == ts_slot_pkg::NS3_OFFS && r.unit_ptr)
        |=> (prdata[29:0] == $past(sq[3].nsec)))
        else $error("third sample read ignores unit pointer");

    a_unit_zero_sec: assert property (
        (setup && paddr == ts_slot_pkg::SEC3_OFFS && !r.unit_ptr)
        |=> (prdata == $past(sq[1].sec)))
        else $error("unit zero third seconds read wrong");

    a_index_read: assert property (
        (setup && paddr == ts_slot_pkg::INDEX_OFFS)
        |=> (!pslverr && prdata[ts_slot_pkg::UNIT_PTR_BIT] == $past(r.unit_ptr)))
        else $error("unit pointer read back wrong");

    a_edge_third: assert property (
        slot_load[1] |=> (sq[1].rising == $past(rise[0])))
        else $error("third sample edge polarity wrong");

    a_edge_unit_one: assert property (
        slot_load[2] |=> (sq[2].rising == $past(rise[1])))
        else $error("unit one edge polarity wrong");

    a_ns_top_zero: assert property (
        (setup && (paddr == ts_slot_pkg::NS2_OFFS || paddr == ts_slot_pkg::NS3_OFFS))
        |=> !prdata[31])
        else $error("reserved nanoseconds bit not zero");

    a_ns_unit_one: assert property (
        slot_load[2] |=> (sq[2].nsec == $past(tc_nsec)))
        else $error("unit one second sample nanoseconds wrong");

    a_ns_third_one: assert property (
        slot_load[3] |=> (sq[3].nsec == $past(tc_nsec)))
        else $error("unit one third sample nanoseconds wrong");

    a_sec_unit_one: assert property (
        slot_load[2] |=> (sq[2].sec == $past(tc_sec)))
        else $error("unit one second sample seconds wrong");

    a_sec_third_one: assert property (
        slot_load[3] |=> (sq[3].sec == $past(tc_sec)))
        else $error("unit one third sample seconds wrong");

    a_phase_capture: assert property (
        slot_load[1] |=> (sq[1].phase == $past(cur_phase)))
        else $error("third sample phase not the slot in force");

    a_phase_restart: assert property (
        tc_tick |=> (cur_phase == ts_slot_pkg::PH_0NS))
        else $error("phase not back at first slot after tick");

    // one slot per clock, since a clock period equals one 8 ns slot
    a_phase_count: assert property (
        (!tc_tick && r.phase_cnt != ts_slot_pkg::PHASE_LAST)
        |=> (r.phase_cnt == $past(r.phase_cnt) + 3'h1))
        else $error("phase slot did not advance");

    a_phase_hold: assert property (
        (!tc_tick && r.phase_cnt == ts_slot_pkg::PHASE_LAST)
        |=> (cur_phase == ts_slot_pkg::PH_32NS))
        else $error("phase left the fifth slot without a tick");

    a_gate_unit_one: assert property (
        (!r.rise_en[1] && !r.fall_en[1] && !clr[1]) |=> (r.cnt[1] == $past(r.cnt[1])))
        else $error("unit one count moved with detection disabled");

    a_rise_disabled: assert property (
        (rise[0] && !r.rise_en[0] && !clr[0]) |=> (r.cnt[0] == $past(r.cnt[0])))
        else $error("disabled rising edge was counted");

    a_ovf_unit_one: assert property (
        (r.cnt[1] == ts_slot_pkg::CNT_MAX && hit[1] && !clr[1])
        |=> (r.ovf[1] && r.cnt[1] == ts_slot_pkg::CNT_MAX))
        else $error("unit one overflow not set or count left 15");

    a_ovf_sticky: assert property (
        (r.ovf[0] && !clr[0]) |=> r.ovf[0])
        else $error("overflow dropped without a clear");

    a_slot_readonly: assert property (
        (wr_acc && !slot_load[0]) |=> (sq[0] == $past(sq[0])))
        else $error("register write changed a sample slot");

    a_unmapped_zero: assert property (
        (setup && paddr[11:8] != 4'h5)
        |=> (pslverr && prdata == ts_slot_pkg::RESET_WORD))
        else $error("unmapped read not refused with zero data");

    a_ph3_reserved: assert property (
        (setup && paddr == ts_slot_pkg::PH3_OFFS) |=> (prdata[31:3] == 29'h0 && !pslverr))
        else $error("reserved third phase bits not zero");
endmodule : ts_sample_regs
`default_nettype wire

// [verif/event_timestamp_sample_slots_tb.sv]
// self-checking bench for the two-unit event timestamp sample slots
// assumes ts_slot_pkg, slot_if and the rtl files are compiled first
`timescale 1ns/10ps
`default_nettype none
module event_timestamp_sample_slots_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, tc_tick, tick_on, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, tc_sec, rnd, r, p2, p3;
    logic [29:0] tc_nsec;
    logic [1:0] evt_pin;
    logic [2:0] tcnt;
    logic [7:0] mask, xm;
    logic [11:0] offs [6];
    logic [31:0] e_ns2 [2], e_s2 [2], e_ns3 [2], e_s3 [2];
    logic [3:0] e_cnt [2];
    logic e_ovf [2];
    int mismatches, checks_done;

    ts_sample_regs i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt_pin(evt_pin), .tc_sec(tc_sec),
        .tc_nsec(tc_nsec), .tc_tick(tc_tick));

    // ==========================================================
    // clock and 40 ns time clock tick
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        tcnt <= (rst || tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
        tc_tick <= !rst && tick_on && (tcnt == 3'h4);
    end

    // ==========================================================
    // expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] ctrl_word(input logic [3:0] c, input logic o);
        return {4'h0, c, 7'h00, o, 16'h0000};
    endfunction : ctrl_word

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : chk

    // ==========================================================
    // apb master: one idle cycle after each transfer keeps psel edges clean
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, d, x, y);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] x);
        logic y;
        apb(1'b0, a, 32'h0000_0000, x, y);
    endtask : rd

    // clear count and overflow, set polarity enables {rise, fall}
    task automatic start(input int u, input logic [1:0] en);
        wr(ts_slot_pkg::INDEX_OFFS, 32'(u) << ts_slot_pkg::UNIT_PTR_BIT);
        wr(ts_slot_pkg::CTRL_OFFS, {1'b1, 23'h000000, en, 6'h00});
        e_cnt[u] = 4'h0;
        e_ovf[u] = 1'b0;
    endtask : start

    // one pin edge at tick offset k; time held long enough to be captured
    task automatic toggle(input int u, input logic [1:0] en, input logic [2:0] k);
        int n;
        logic nv;
        n = 0;
        while (tcnt !== k && n < 8) begin
            @(posedge clk);
            n++;
        end
        nv = ~evt_pin[u];
        rnd = lfsr(rnd);
        tc_sec <= rnd;
        r = rnd;
        rnd = lfsr(rnd);
        tc_nsec <= rnd[29:0];
        evt_pin[u] <= nv;
        if ((nv && en[1]) || (!nv && en[0])) begin
            if (e_cnt[u] == ts_slot_pkg::CNT_MAX) e_ovf[u] = 1'b1;
            else e_cnt[u] = e_cnt[u] + 4'h1;
            if (!e_ovf[u] && e_cnt[u] == 4'h2) begin
                e_ns2[u] = {1'b0, nv, rnd[29:0]};
                e_s2[u] = r;
            end
            if (!e_ovf[u] && e_cnt[u] == 4'h3) begin
                e_ns3[u] = {1'b0, nv, rnd[29:0]};
                e_s3[u] = r;
            end
        end
        repeat (6) @(posedge clk);
    endtask : toggle

    task automatic chk_unit(input int u, output logic [31:0] q2, output logic [31:0] q3);
        logic [31:0] x;
        wr(ts_slot_pkg::INDEX_OFFS, 32'(u) << ts_slot_pkg::UNIT_PTR_BIT);
        rd(ts_slot_pkg::NS2_OFFS, x);
        chk(x, e_ns2[u]);
        rd(ts_slot_pkg::SEC2_OFFS, x);
        chk(x, e_s2[u]);
        rd(ts_slot_pkg::NS3_OFFS, x);
        chk(x, e_ns3[u]);
        rd(ts_slot_pkg::SEC3_OFFS, x);
        chk(x, e_s3[u]);
        rd(ts_slot_pkg::CTRL_OFFS, x);
        chk(x & 32'h0F01_0000, ctrl_word(e_cnt[u], e_ovf[u]));
        rd(ts_slot_pkg::PH2_OFFS, q2);
        rd(ts_slot_pkg::PH3_OFFS, q3);
    endtask : chk_unit

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end

    // ==========================================================
    // tests
    initial begin
        {rst, tick_on} = 2'b11;
        {psel, penable, pwrite} = 3'h0;
        {paddr, pwdata, evt_pin, tc_sec, tc_nsec} = '0;
        rnd = 32'h0000_0B26;
        mismatches = 0;
        checks_done = 0;
        offs = '{ts_slot_pkg::NS2_OFFS, ts_slot_pkg::SEC2_OFFS, ts_slot_pkg::PH2_OFFS,
                 ts_slot_pkg::NS3_OFFS, ts_slot_pkg::SEC3_OFFS, ts_slot_pkg::PH3_OFFS};
        for (int u = 0; u < 2; u++) begin
            {e_ns2[u], e_s2[u], e_ns3[u], e_s3[u], e_cnt[u], e_ovf[u]} = '0;
        end
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int u = 0; u < 2; u++) begin
            chk_unit(u, p2, p3);
            chk(p2 | p3, ts_slot_pkg::RESET_WORD);
        end
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr(offs[i], rnd);
        end
        chk_unit(0, p2, p3);
        chk(p2 | p3, ts_slot_pkg::RESET_WORD);
        apb(1'b0, 12'h7FC, 32'h0000_0000, r, e);
        chk(r, ts_slot_pkg::RESET_WORD);
        chk({31'h0, e}, 32'h0000_0001);
        $display("test reset_and_access done");
        // unit 1 captures, unit 0 must stay untouched
        start(1, 2'b11);
        repeat (3) toggle(1, 2'b11, 3'h2);
        chk_unit(1, p2, p3);
        chk_unit(0, p2, p3);
        $display("test unit_pointer done");
        for (int m = 1; m < 3; m++) begin
            start(0, 2'(m));
            repeat (5) toggle(0, 2'(m), 3'h1);
            chk_unit(0, p2, p3);
        end
        $display("test single_polarity done");
        // later edges must not disturb the slots, and they survive a clear
        start(1, 2'b11);
        repeat (18) toggle(1, 2'b11, 3'h3);
        chk_unit(1, p2, p3);
        wr(ts_slot_pkg::CTRL_OFFS, 32'h8000_00C0);
        {e_cnt[1], e_ovf[1]} = 5'h00;
        chk_unit(1, p2, p3);
        $display("test overflow done");
        // every tick offset must give its own code; code exactness left to latency
        mask = 8'h00;
        for (int k = 0; k < 5; k++) begin
            start(0, 2'b11);
            repeat (3) toggle(0, 2'b11, 3'(k));
            chk_unit(0, p2, p3);
            chk(p3, p2);
            chk(p2 & 32'hFFFF_FFF8, ts_slot_pkg::RESET_WORD);
            mask[p2[2:0]] = 1'b1;
        end
        xm = 8'h00;
        xm[ts_slot_pkg::PH_0NS] = 1'b1;
        xm[ts_slot_pkg::PH_8NS] = 1'b1;
        xm[ts_slot_pkg::PH_16NS_DEFAULT] = 1'b1;
        xm[ts_slot_pkg::PH_24NS] = 1'b1;
        xm[ts_slot_pkg::PH_32NS] = 1'b1;
        chk({24'h000000, mask}, {24'h000000, xm});
        // with no tick the slot count saturates at the fifth slot
        tick_on <= 1'b0;
        repeat (12) @(posedge clk);
        start(0, 2'b11);
        repeat (3) toggle(0, 2'b11, 3'h0);
        chk_unit(0, p2, p3);
        chk(p2, {29'h0, ts_slot_pkg::PH_32NS});
        chk(p3, {29'h0, ts_slot_pkg::PH_32NS});
        $display("test phase_codes done");
        tally_and_finish;
    end
endmodule : event_timestamp_sample_slots_tb
`default_nettype wire
